// file: rtl/scr_pkg.sv
// package for the sdram command rate controller
// assumes one host clock domain and pre-decoded bank/row/column requests
package scr_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W     = 14;
    localparam int BANK_W     = 2;
    localparam int ROW_W      = 14;
    localparam int COL_W      = 9;
    localparam int OPEN_PAGES = 2;

    // ==========================================================
    // timing counts (clk_sys cycles)
    localparam logic [2:0] CL_TWO_CYC    = 3'h2;
    localparam logic [2:0] CL_THREE_CYC  = 3'h3;
    localparam logic [1:0] FAST_GAP_CYC  = 2'h1;
    localparam logic [1:0] SLOW_GAP_CYC  = 2'h2;
    localparam logic [1:0] EDO_FAST_WAIT = 2'h0;
    localparam logic [1:0] EDO_SLOW_WAIT = 2'h1;
    localparam int         BURST_LEN     = 4;

    // ==========================================================
    // command encodings
    typedef enum logic [2:0] {
        CMD_NOP   = 3'b000,
        CMD_ACT   = 3'b001,
        CMD_READ  = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_PRE   = 3'b100
    } scr_cmd_type;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic              write;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
        logic              burst4;
    } scr_req_type;

    typedef struct packed {
        scr_cmd_type        cmd;
        logic [BANK_W-1:0]  bank;
        logic [ADDR_W-1:0]  addr;
    } scr_mem_cmd_type;

endpackage : scr_pkg

// file: rtl/scr_page_table.sv
// open page tracker: holds at most two open sdram pages
// assumes the scheduler opens only after a free slot or a close
module scr_page_table
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // lookup
    input  wire logic [BANK_W-1:0] lookBank,
    input  wire logic [ROW_W-1:0]  lookRow,
    output logic                   pageHit,
    output logic                   bankOpen,
    output logic                   slotFree,
    output logic                   victimSlot,
    // update
    input  wire logic              openPage,
    input  wire logic              closePage,
    input  wire logic [BANK_W-1:0] updBank,
    input  wire logic [ROW_W-1:0]  updRow
);

    // ==========================================================
    // storage
    logic [OPEN_PAGES-1:0] valid_r, valid_nxt;
    logic [BANK_W-1:0]     bank_r [OPEN_PAGES];
    logic [BANK_W-1:0]     bank_nxt [OPEN_PAGES];
    logic [ROW_W-1:0]      row_r [OPEN_PAGES];
    logic [ROW_W-1:0]      row_nxt [OPEN_PAGES];
    logic                  lru_r, lru_nxt;

    // ==========================================================
    // lookup
    always_comb
    begin
        pageHit  = 1'b0;
        bankOpen = 1'b0;
        for (int i = 0; i < OPEN_PAGES; i++)
        begin
            if (valid_r[i] && bank_r[i] == lookBank)
            begin
                bankOpen = 1'b1;
                if (row_r[i] == lookRow)
                    pageHit = 1'b1;
            end
        end
        slotFree   = ~&valid_r;
        victimSlot = lru_r;
    end

    // ==========================================================
    // update: never more than two pages, even with four banks
    always_comb
    begin
        valid_nxt = valid_r;
        bank_nxt  = bank_r;
        row_nxt   = row_r;
        lru_nxt   = lru_r;
        for (int i = 0; i < OPEN_PAGES; i++)
        begin
            if (closePage && valid_r[i] && bank_r[i] == updBank)
                valid_nxt[i] = 1'b0;
        end
        if (openPage)
        begin
            if (!valid_nxt[0])
            begin
                valid_nxt[0] = 1'b1;
                bank_nxt[0]  = updBank;
                row_nxt[0]   = updRow;
                lru_nxt      = 1'b1;
            end
            else
            begin
                valid_nxt[1] = 1'b1;
                bank_nxt[1]  = updBank;
                row_nxt[1]   = updRow;
                lru_nxt      = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            valid_r <= '0;
            lru_r   <= 1'b0;
            for (int i = 0; i < OPEN_PAGES; i++)
            begin
                bank_r[i] <= '0;
                row_r[i]  <= '0;
            end
        end
        else
        begin
            valid_r <= valid_nxt;
            lru_r   <= lru_nxt;
            bank_r  <= bank_nxt;
            row_r   <= row_nxt;
        end
    end

endmodule : scr_page_table

// file: rtl/scr_command_rate.sv
// sdram command issue and read data scheduling at host clock rate
// assumes requests come from logic on clk_sys and mode pins are held static
module scr_command_rate
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // mode straps
    input  wire logic            addrWaitStateSelect,
    input  wire logic            casLatencySetting,
    input  wire logic            fourBankParts,
    input  wire logic            edoMode,
    // request
    input  wire logic            reqValid,
    input  wire scr_req_type     reqData,
    output logic                 reqReady,
    // memory command
    output scr_mem_cmd_type      memCmd,
    // read data timing
    output logic                 rdDataExpect,
    output logic                 singleClockMode,
    output logic [1:0]           edoWaitStates
);

    // ==========================================================
    // strap synchroniser: straps come from board pins
    // no reset, so the straps settle while rst is still held
    logic [3:0] strapMeta_r;
    logic [3:0] strapSync_r;
    logic       selSync;
    logic       clSync;
    logic       fourSync;
    logic       edoSync;

    always_ff @(posedge clk_sys)
    begin
        strapMeta_r <= {addrWaitStateSelect, casLatencySetting, fourBankParts, edoMode};
        strapSync_r <= strapMeta_r;
    end

    assign {selSync, clSync, fourSync, edoSync} = strapSync_r;

    // ==========================================================
    // mode decode: 1 selects zero wait states, and fast single clock mode when edoMode is 0
    logic fastMode;
    assign fastMode        = selSync & ~edoSync;
    assign singleClockMode = fastMode;
    assign edoWaitStates   = selSync ? EDO_FAST_WAIT : EDO_SLOW_WAIT;

    function automatic logic [ADDR_W-1:0] col_addr(input logic [COL_W-1:0] c);
        col_addr = ADDR_W'(c);
    endfunction : col_addr

    function automatic logic [BANK_W-1:0] bank_mask(input logic [BANK_W-1:0] b,
                                                    input logic four);
        // two-bank parts only decode the low bank bit
        bank_mask = four ? b : {1'b0, b[0]};
    endfunction : bank_mask

    // ==========================================================
    // page table
    logic              pageHit, bankOpen, slotFree;
    logic              openPage, closePage;
    logic [BANK_W-1:0] updBank;
    logic [BANK_W-1:0] reqBank;
    assign reqBank = bank_mask(reqData.bank, fourSync);

    scr_page_table u_pages (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .lookBank   (reqBank),
        .lookRow    (reqData.row),
        .pageHit    (pageHit),
        .bankOpen   (bankOpen),
        .slotFree   (slotFree),
        .victimSlot (),
        .openPage   (openPage),
        .closePage  (closePage),
        .updBank    (updBank),
        .updRow     (reqData.row)
    );

    // ==========================================================
    // issue control
    logic [1:0]        gap_r, gap_nxt;
    // longest latency plus a four-word burst needs six slots
    localparam int               EXP_W      = 6;
    localparam logic [EXP_W-1:0] EXP_ONES   = '1;
    localparam logic [EXP_W-1:0] BURST_BITS = EXP_W'((1 << BURST_LEN) - 1);

    logic [BANK_W-1:0] lastBank_r, lastBank_nxt;
    scr_mem_cmd_type   cmd_r, cmd_nxt;
    logic [EXP_W-1:0]  expect_r, expect_nxt;
    logic [2:0]        latency;
    logic              canIssue;

    assign latency  = clSync ? CL_THREE_CYC : CL_TWO_CYC;
    // both modes wait out the gap; fast mode column commands leave no gap
    assign canIssue = (gap_r == 2'h0);

    always_comb
    begin
        gap_nxt       = (gap_r != 2'h0) ? gap_r - 2'h1 : 2'h0;
        lastBank_nxt  = lastBank_r;
        cmd_nxt       = '{cmd: CMD_NOP, bank: '0, addr: '0};
        reqReady      = 1'b0;
        openPage      = 1'b0;
        closePage     = 1'b0;
        updBank       = reqBank;
        // data expectation: shift register indexed by latency
        expect_nxt    = {1'b0, expect_r[EXP_W-1:1]};
        if (reqValid && canIssue)
        begin
            if (pageHit)
            begin
                // column command; fast mode every clock
                reqReady = 1'b1;
                cmd_nxt  = '{cmd: reqData.write ? CMD_WRITE : CMD_READ,
                             bank: reqBank, addr: col_addr(reqData.col)};
                gap_nxt  = (fastMode ? FAST_GAP_CYC : SLOW_GAP_CYC) - 2'h1;
                if (!reqData.write)
                begin
                    // new read cuts words still due from an earlier burst
                    expect_nxt = (expect_r >> 1) & ~(EXP_ONES << (latency - 3'h1));
                    if (reqData.burst4)
                    begin
                        // four-word burst streams x111 regardless of mode
                        expect_nxt = expect_nxt | (BURST_BITS << (latency - 3'h1));
                    end
                    else
                        expect_nxt[latency-3'h1] = 1'b1;
                end
            end
            else if (bankOpen || !slotFree)
            begin
                // close wrong page or the most recently opened one to keep two open
                closePage = 1'b1;
                updBank   = bankOpen ? reqBank : lastBank_r;
                cmd_nxt   = '{cmd: CMD_PRE, bank: updBank, addr: '0};
                gap_nxt   = SLOW_GAP_CYC - 2'h1;
            end
            else
            begin
                openPage     = 1'b1;
                lastBank_nxt = reqBank;
                cmd_nxt      = '{cmd: CMD_ACT, bank: reqBank, addr: ADDR_W'(reqData.row)};
                gap_nxt      = SLOW_GAP_CYC - 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            gap_r       <= '0;
            lastBank_r  <= '0;
            cmd_r       <= '{cmd: CMD_NOP, bank: '0, addr: '0};
            expect_r    <= '0;
        end
        else
        begin
            gap_r       <= gap_nxt;
            lastBank_r  <= lastBank_nxt;
            cmd_r       <= cmd_nxt;
            expect_r    <= expect_nxt;
        end
    end

    assign memCmd       = cmd_r;
    assign rdDataExpect = expect_r[0];

endmodule : scr_command_rate

// file: dv/scr_command_rate_props.sv
// checker on the ports of scr_command_rate
// assumes a bind from the bench top, one clock domain
module scr_command_rate_props
    import scr_pkg::*;
(
    // clock and reset
    input wire logic            clk_sys,
    input wire logic            rst,
    // straps and request
    input wire logic            addrWaitStateSelect,
    input wire logic            casLatencySetting,
    input wire logic            edoMode,
    input wire logic            reqValid,
    input wire scr_req_type     reqData,
    input wire logic            reqReady,
    // outputs
    input wire scr_mem_cmd_type memCmd,
    input wire logic            rdDataExpect,
    input wire logic            singleClockMode,
    input wire logic [1:0]      edoWaitStates
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // helpers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       rdTake;
    logic [3:0] open_r;
    logic [3:0] open_nxt;
    assign rdTake = reqValid && reqReady && !reqData.write;
    always_comb
    begin
        open_nxt = open_r;
        if (memCmd.cmd == CMD_ACT) open_nxt[memCmd.bank] = 1'b1;
        if (memCmd.cmd == CMD_PRE) open_nxt[memCmd.bank] = 1'b0;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst) open_r <= '0;
        else open_r <= open_nxt;
    end
    // ==========================================================
    // properties
    a_cl_two_data: assert property (rdTake && !casLatencySetting |-> ##2 rdDataExpect)
        else $error("read data not two clocks after take");
    a_cl_three_data: assert property (rdTake && casLatencySetting |-> ##3 rdDataExpect)
        else $error("read data not three clocks after take");
    a_slow_cmd_gap: assert property (!singleClockMode && memCmd.cmd != CMD_NOP
        |=> memCmd.cmd == CMD_NOP) else $error("slow mode command without gap");
    a_slow_take_gap: assert property (!singleClockMode && reqValid && reqReady
        |=> !reqReady) else $error("slow mode took on consecutive clocks");
    a_fast_mode_map: assert property (singleClockMode == (addrWaitStateSelect && !edoMode))
        else $error("single clock mode does not follow select");
    a_edo_wait_step: assert property (edoWaitStates ==
        (addrWaitStateSelect ? EDO_FAST_WAIT : EDO_SLOW_WAIT)) else $error("edo wait wrong");
    a_take_issues_col: assert property (reqValid && reqReady |=> memCmd.cmd ==
        ($past(reqData.write) ? CMD_WRITE : CMD_READ)) else $error("take without column cmd");
    a_burst_stream: assert property (rdTake && reqData.burst4 && !casLatencySetting
        ##1 !rdTake [*2] |-> rdDataExpect [*4]) else $error("burst data not streamed");
    a_two_pages_max: assert property ($countones(open_r) <= 2)
        else $error("more than two pages open");
    c_fast_b2b: cover property (singleClockMode && reqReady ##1 reqReady);
endmodule : scr_command_rate_props

// file: dv/scr_sdram_model.sv
// sdram dimm model: follows bank state from the command bus
// assumes memCmd is registered on clk_sys
module scr_sdram_model
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // command bus
    input  wire scr_mem_cmd_type memCmd,
    // observation
    output logic [2:0]           openCnt,
    output logic                 badRead
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] open_r;
    // sticky flag, so a single bad read is never missed
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            open_r  <= '0;
            badRead <= 1'b0;
        end
        else
        begin
            if (memCmd.cmd == CMD_ACT) open_r[memCmd.bank] <= 1'b1;
            if (memCmd.cmd == CMD_PRE) open_r[memCmd.bank] <= 1'b0;
            if (memCmd.cmd == CMD_READ && !open_r[memCmd.bank]) badRead <= 1'b1;
        end
    end
    assign openCnt = 3'($countones(open_r));
endmodule : scr_sdram_model

// file: dv/scr_command_rate_tb_top.sv
// bench for scr_command_rate with dimm model and bound checker
// assumes straps change only while rst is high
module scr_command_rate_tb_top
    import scr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic s, c, f, e; logic [1:0] b; int lat; logic scm; logic [1:0] ws;} scr_row_type;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic            sel = 1'b0, cl = 1'b0, four = 1'b0, edo = 1'b0, reqValid = 1'b0;
    scr_req_type     reqData = '0;
    logic            reqReady, rdDataExpect, singleClockMode, badRead;
    scr_mem_cmd_type memCmd;
    logic [1:0]      edoWaitStates;
    logic [2:0]      openCnt;
    int              n_mismatch = 0, n_checks = 0, cyc = 0, tk, first, n, s, nWords;
    scr_row_type     rw;
    // straps kept to a legal three-dimm x16 board
    scr_row_type     rows [6] = '{'{0,0,0,0,0,2,0,1}, '{1,0,1,0,3,2,1,0},
        '{0,1,1,0,2,3,0,1}, '{1,1,0,0,1,3,1,0}, '{1,0,0,1,2,2,0,0}, '{0,0,0,1,0,2,0,1}};
    scr_command_rate uut (.clk_sys(clk_sys), .rst(rst), .addrWaitStateSelect(sel),
        .casLatencySetting(cl), .fourBankParts(four), .edoMode(edo), .reqValid(reqValid),
        .reqData(reqData), .reqReady(reqReady), .memCmd(memCmd), .rdDataExpect(rdDataExpect),
        .singleClockMode(singleClockMode), .edoWaitStates(edoWaitStates));
    scr_sdram_model mdl (.clk_sys(clk_sys), .rst(rst), .memCmd(memCmd), .openCnt(openCnt),
        .badRead(badRead));
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    // data words seen since the last reset
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            nWords <= 0;
        else if (rdDataExpect === 1'b1)
            nWords <= nWords + 1;
    end
    // ==========================================================
    // tasks
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task reset_to(input logic ws, input logic wc, input logic wf, input logic we, input int k);
        @(negedge clk_sys);
        rst = 1'b1;
        {sel, cl, four, edo} = {ws, wc, wf, we};
        repeat (k) @(negedge clk_sys);
        rst = 1'b0;
    endtask : reset_to
    // request held until the edge that takes it; tk is that edge
    task send(input logic [1:0] b, input logic [13:0] r, input logic b4);
        reqData = '{write: 1'b0, bank: b, row: r, col: 9'h005, burst4: b4};
        reqValid = 1'b1;
        tk = -1;
        for (int i = 0; i < 20 && tk < 0; i++)
        begin
            #9;
            if (reqReady === 1'b1) tk = cyc;
            @(negedge clk_sys);
        end
        if (tk < 0) check("take", 0, 1);
        if (tk < 0) test_done();
    endtask : send
    task ones(output int k);
        k = 0;
        repeat (10)
        begin
            if (rdDataExpect === 1'b1) k++;
            @(negedge clk_sys);
        end
    endtask : ones
    // ==========================================================
    // sequence
    initial
    begin
        reset_to(1'b0, 1'b0, 1'b0, 1'b0, 5);
        foreach (rows[i])
        begin
            rw = rows[i];
            reset_to(rw.s, rw.c, rw.f, rw.e, 2);
            send(rw.b, 14'h0011, 1'b0);
            reqValid = 1'b0;
            check("read cmd", memCmd.cmd, CMD_READ);
            check("col addr", memCmd.addr, 14'h0005);
            check("bank", memCmd.bank, rw.f ? rw.b : {1'b0, rw.b[0]});
            n = 1;
            while (rdDataExpect !== 1'b1 && n < 10)
            begin
                @(negedge clk_sys);
                n++;
            end
            if (!rw.e) check("latency", n, rw.lat);
            check("single clock", singleClockMode, rw.scm);
            check("wait states", edoWaitStates, rw.ws);
        end
        for (s = 0; s < 2; s++)
        begin
            reset_to(s[0], 1'b0, 1'b1, 1'b0, 2);
            send(2'h0, 14'h0005, 1'b0);
            first = tk;
            repeat (3) send(2'h0, 14'h0005, 1'b0);
            reqValid = 1'b0;
            check("take span", tk - first, s ? 3 * FAST_GAP_CYC : 3 * SLOW_GAP_CYC);
            ones(n);
            check("data words", nWords, 4);
            // latency 2: words left after the last take are two divided by the gap length
            check("tail words", n, s ? 2 : 1);
        end
        reset_to(1'b0, 1'b0, 1'b0, 1'b0, 2);
        send(2'h0, 14'h0007, 1'b1);
        reqValid = 1'b0;
        ones(n);
        check("burst words", n, BURST_LEN);
        reset_to(1'b1, 1'b0, 1'b1, 1'b0, 2);
        send(2'h0, 14'h0001, 1'b0);
        send(2'h1, 14'h0002, 1'b0);
        send(2'h2, 14'h0003, 1'b1);
        reqValid = 1'b0;
        check("pages", openCnt <= 3'h2, 1'b1);
        check("closed read", badRead, 1'b0);
        rst = 1'b1;
        #1;
        check("reset cmd", memCmd.cmd, CMD_NOP);
        check("reset data", rdDataExpect, 1'b0);
        @(negedge clk_sys);
        rst = 1'b0;
        test_done();
    end
endmodule : scr_command_rate_tb_top
bind scr_command_rate scr_command_rate_props chk (.clk_sys(clk_sys), .rst(rst),
    .addrWaitStateSelect(addrWaitStateSelect), .casLatencySetting(casLatencySetting),
    .edoMode(edoMode), .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
    .memCmd(memCmd), .rdDataExpect(rdDataExpect), .singleClockMode(singleClockMode),
    .edoWaitStates(edoWaitStates));
